// >>> pms_pkg.sv
// Constants shared by the power mode sequencer: register map, fields and reset values.
package pms_pkg;
  // ******************************
  // Register byte addresses
  // ******************************
  localparam logic [7:0] PLL_CONTROL_REG_ADDR = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_REG_ADDR = 8'h04;
  localparam logic [7:0] CMD_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;

  // ******************************
  // pll_control_reg fields
  // ******************************
  localparam int MULT_LSB = 0;
  localparam int MULT_BITS = 7;
  localparam int BYPASS_BIT = 8;
  localparam int PLL_OFF_BIT = 9;
  localparam logic [31:0] PLL_CONTROL_REG_RST = 32'h0000_0006;

  // ******************************
  // regulator_control_reg fields
  // ******************************
  localparam int RATE_LSB = 0;
  localparam logic [1:0] RATE_HIBERNATE = 2'h0;
  localparam int WAKE_PIN_EN_BIT = 8;
  localparam int RTC_EN_BIT = 9;
  localparam int RESET_EN_BIT = 10;
  localparam int SDRAM_CLOCK_ENABLE_LOW_BIT = 13;
  localparam logic [31:0] REGULATOR_CONTROL_REG_RST = 32'h0000_0403;

  // ******************************
  // Command codes and status fields
  // ******************************
  localparam logic [1:0] CMD_SLEEP = 2'h1;
  localparam logic [1:0] CMD_DEEP = 2'h2;
  localparam logic [1:0] CMD_RUN = 2'h3;
  localparam int STAT_MULT_LSB = 8;
  localparam int STAT_PG_BIT = 16;

  // ******************************
  // Interrupt bits and synchroniser layout
  // ******************************
  localparam int IRQ_BITS = 4;
  localparam int IRQ_SLEEP_WAKE = 0;
  localparam int IRQ_DEEP_WAKE = 1;
  localparam int IRQ_HIB_WAKE = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int SYNC_BITS = 5;
  localparam logic [4:0] SYNC_RST = 5'h1C;

  typedef enum logic [2:0] {S_FULL, S_ACT, S_SLEEP, S_DEEP, S_HIB, S_RSTSEQ} mode_t;
endpackage

// >>> power_mode_sequencer.sv
// Operating-mode sequencer: clock gating, PLL control, regulator handshake, Wishbone registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Power-up lands in full-on: PLL on, not bypassed, both clocks running.
// - Active mode bypasses the PLL; core and system clocks run at input rate.
// - Multiplier written in active mode takes effect only on the next full-on entry.
// - Sleep stops the core clock; PLL and system clock keep running.
// - Sleep wakeup goes to full-on if bypass is clear, else active.
// - No system DMA access to level-1 memory while sleeping.
// - Deep sleep turns off PLL and both clocks; async blocks lose bus access.
// - Deep sleep exits only on reset or real-time clock interrupt.
// - From deep sleep, real-time clock goes active and reset goes full-on.
// - Writing rate 00 drops the regulator wake line and enters hibernate.
// - In hibernate all pads float except the regulator wake line.
// - Each hibernate wake source has its own enable in the regulator register.
// - Any enabled hibernate wake starts the reset sequence and raises regulator wake.
// - Regulator wake is high when the core supply should be on.
// - Only the regulator register survives hibernate; others return to reset values.
// - With sdram_clock_enable_low set, SDRAM self-refresh holds through hibernate and reset sequence.
// - After hibernate wakeup, start waits until power good reads low.
module power_mode_sequencer #(
  parameter int MULT_W = 7
) (
  // System
  input wire logic CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ,
  // Wake sources and regulator
  input wire logic SLEEP_WAKE,
  input wire logic RTC_WAKE,
  input wire logic WAKE_PIN_N,
  input wire logic RESET_PIN_N,
  input wire logic POWER_GOOD_N,
  output logic REG_WAKE,
  // Clock and PLL control
  output logic CORE_CLK_EN,
  output logic SYS_CLK_EN,
  output logic PLL_EN,
  output logic PLL_BYPASS,
  output logic [MULT_W-1:0] PLL_MULT,
  // System side effects
  output logic DMA_L1_EN,
  output logic ASYNC_ACCESS_EN,
  output logic PADS_HIZ,
  output logic SDRAM_SELF_REFRESH,
  output logic SEQ_RESET
);
  // ******************************
  // Elaboration checks
  // ******************************
  if (MULT_W < pms_pkg::MULT_BITS) begin : g_bad_mult
    $error("MULT_W too narrow for multipliers up to 64");
  end

  // ******************************
  // Pin synchronisers
  // ******************************
  // Bit order: sleep wake, rtc, wake pin, reset pin, power good.
  logic [4:0] pins_in;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  assign pins_in = {POWER_GOOD_N, RESET_PIN_N, WAKE_PIN_N, RTC_WAKE, SLEEP_WAKE};

  for (genvar i = 0; i < pms_pkg::SYNC_BITS; i++) begin : g_sync
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        sync1_ff[i] <= pms_pkg::SYNC_RST[i];
        sync2_ff[i] <= pms_pkg::SYNC_RST[i];
      end else begin
        sync1_ff[i] <= pins_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  wire sleep_wake = sync2_ff[0];
  wire rtc_wake = sync2_ff[1];
  wire pin_wake = !sync2_ff[2];
  wire reset_pin = !sync2_ff[3];
  wire power_good = !sync2_ff[4];

  // ******************************
  // Wishbone decode
  // ******************************
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] pll_control_reg_ff;
  logic [31:0] regulator_control_reg_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [MULT_W-1:0] applied_ff;
  pms_pkg::mode_t state_ff;
  pms_pkg::mode_t nxt_state;

  wire req = CYC_I && STB_I;
  wire take = req && !ack_ff;
  wire fire = req && ack_ff;
  wire wr = fire && WE_I;
  wire rd_fire = fire && !WE_I;
  wire hit_pll = ADR_I == pms_pkg::PLL_CONTROL_REG_ADDR;
  wire hit_vr = ADR_I == pms_pkg::REGULATOR_CONTROL_REG_ADDR;
  wire hit_cmd = ADR_I == pms_pkg::CMD_ADDR;
  wire hit_stat = ADR_I == pms_pkg::IRQ_STAT_ADDR;
  wire hit_mask = ADR_I == pms_pkg::IRQ_MASK_ADDR;
  wire [31:0] wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [31:0] pll_wr = merge(pll_control_reg_ff, DAT_I, wmask);
  wire [31:0] vr_wr = merge(regulator_control_reg_ff, DAT_I, wmask);
  wire [31:0] mask_wr = merge({28'h000_0000, irq_mask_ff}, DAT_I, wmask);

  // Register fields.
  wire bypass_sel = pll_control_reg_ff[pms_pkg::BYPASS_BIT];
  wire pll_off = pll_control_reg_ff[pms_pkg::PLL_OFF_BIT];
  wire [MULT_W-1:0] mult_req = pll_control_reg_ff[pms_pkg::MULT_LSB +: MULT_W];
  wire sdram_clock_enable_low = regulator_control_reg_ff[pms_pkg::SDRAM_CLOCK_ENABLE_LOW_BIT];
  wire en_pin = regulator_control_reg_ff[pms_pkg::WAKE_PIN_EN_BIT];
  wire en_rtc = regulator_control_reg_ff[pms_pkg::RTC_EN_BIT];
  wire en_rst = regulator_control_reg_ff[pms_pkg::RESET_EN_BIT];

  // Commands and hibernate entry.
  wire running = (state_ff == pms_pkg::S_FULL) || (state_ff == pms_pkg::S_ACT);
  wire cmd_wr = wr && hit_cmd && SEL_I[0] && running;
  wire [1:0] cmd = DAT_I[1:0];
  wire hib_wr = wr && hit_vr && SEL_I[0] && running &&
                vr_wr[pms_pkg::RATE_LSB +: 2] == pms_pkg::RATE_HIBERNATE;
  // Full-on or sleep with the PLL switched off is refused and flagged.
  wire refuse = cmd_wr && pll_off && (cmd == pms_pkg::CMD_SLEEP ||
                (cmd == pms_pkg::CMD_RUN && !bypass_sel));

  // ******************************
  // Mode sequencing
  // ******************************
  wire hib_wake = (en_pin && pin_wake) || (en_rtc && rtc_wake) ||
                  (en_rst && reset_pin);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pms_pkg::S_FULL, pms_pkg::S_ACT: begin
        if (hib_wr) begin
          nxt_state = pms_pkg::S_HIB;
        end else if (cmd_wr && !refuse) begin
          unique case (cmd)
            pms_pkg::CMD_SLEEP: nxt_state = pms_pkg::S_SLEEP;
            pms_pkg::CMD_DEEP: nxt_state = pms_pkg::S_DEEP;
            pms_pkg::CMD_RUN: nxt_state = bypass_sel ? pms_pkg::S_ACT : pms_pkg::S_FULL;
            default: nxt_state = state_ff;
          endcase
        end
      end
      pms_pkg::S_SLEEP: begin
        if (sleep_wake || rtc_wake) begin
          nxt_state = bypass_sel ? pms_pkg::S_ACT : pms_pkg::S_FULL;
        end
      end
      pms_pkg::S_DEEP: begin
        if (reset_pin) begin
          nxt_state = pms_pkg::S_FULL;
        end else if (rtc_wake) begin
          nxt_state = pms_pkg::S_ACT;
        end
      end
      pms_pkg::S_HIB: begin
        if (hib_wake) begin
          nxt_state = pms_pkg::S_RSTSEQ;
        end
      end
      pms_pkg::S_RSTSEQ: begin
        if (power_good) begin
          nxt_state = pms_pkg::S_FULL;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= pms_pkg::S_FULL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ******************************
  // Registers
  // ******************************
  // Everything but the regulator register is cleared while the reset sequence
  // runs, standing in for the content lost with the core supply.
  wire wiped = (state_ff == pms_pkg::S_HIB) || (state_ff == pms_pkg::S_RSTSEQ);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pll_control_reg_ff <= pms_pkg::PLL_CONTROL_REG_RST;
      irq_mask_ff <= 4'h0;
    end else if (wiped) begin
      pll_control_reg_ff <= pms_pkg::PLL_CONTROL_REG_RST;
      irq_mask_ff <= 4'h0;
    end else begin
      if (wr && hit_pll) begin
        pll_control_reg_ff <= pll_wr;
      end
      if (wr && hit_mask) begin
        irq_mask_ff <= mask_wr[3:0];
      end
    end
  end

  // The regulator register is only reset by power-up.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      regulator_control_reg_ff <= pms_pkg::REGULATOR_CONTROL_REG_RST;
    end else if (wr && hit_vr && running) begin
      regulator_control_reg_ff <= vr_wr;
    end
  end

  // The applied multiplier follows the request only in full-on, so a change
  // made in active mode waits for the next full-on entry.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      applied_ff <= pms_pkg::PLL_CONTROL_REG_RST[MULT_W-1:0];
    end else if (wiped) begin
      applied_ff <= pms_pkg::PLL_CONTROL_REG_RST[MULT_W-1:0];
    end else if (state_ff == pms_pkg::S_FULL) begin
      applied_ff <= mult_req;
    end
  end

  // ******************************
  // Interrupts
  // ******************************
  wire [3:0] irq_set;
  assign irq_set[pms_pkg::IRQ_SLEEP_WAKE] = state_ff == pms_pkg::S_SLEEP &&
                                            nxt_state != pms_pkg::S_SLEEP;
  assign irq_set[pms_pkg::IRQ_DEEP_WAKE] = state_ff == pms_pkg::S_DEEP &&
                                           nxt_state != pms_pkg::S_DEEP;
  assign irq_set[pms_pkg::IRQ_HIB_WAKE] = state_ff == pms_pkg::S_RSTSEQ && power_good;
  assign irq_set[pms_pkg::IRQ_REFUSED] = refuse;
  wire stat_clr = rd_fire && hit_stat;
  // Only the bits that the read returned are cleared, so an event that lands
  // between the data capture and the acknowledge is not lost.
  wire [3:0] stat_keep = stat_clr ? ~dat_ff[3:0] : 4'hF;

  // A new event wins over the read that clears the register.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_ff <= 4'h0;
    end else if (wiped) begin
      irq_stat_ff <= irq_set;
    end else begin
      irq_stat_ff <= (irq_stat_ff & stat_keep) | irq_set;
    end
  end

  // ******************************
  // Bus answer
  // ******************************
  wire [2:0] mode_code = state_ff;
  wire [31:0] status_word = {15'h0000, power_good, 1'b0, applied_ff, 5'h00, mode_code};
  wire [31:0] rd_data = hit_pll ? pll_control_reg_ff :
                        hit_vr ? regulator_control_reg_ff :
                        hit_cmd ? status_word :
                        hit_stat ? {28'h000_0000, irq_stat_ff} :
                        hit_mask ? {28'h000_0000, irq_mask_ff} : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      dat_ff <= take ? rd_data : 32'h0000_0000;
    end
  end

  // ******************************
  // Mode outputs
  // ******************************
  wire m_full = state_ff == pms_pkg::S_FULL;
  wire m_act = state_ff == pms_pkg::S_ACT;
  wire m_sleep = state_ff == pms_pkg::S_SLEEP;
  wire m_hib = state_ff == pms_pkg::S_HIB;
  wire m_seq = state_ff == pms_pkg::S_RSTSEQ;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_CLK_EN <= 1'b1;
      SYS_CLK_EN <= 1'b1;
      PLL_EN <= 1'b1;
      PLL_BYPASS <= 1'b0;
      PLL_MULT <= pms_pkg::PLL_CONTROL_REG_RST[MULT_W-1:0];
      DMA_L1_EN <= 1'b1;
      ASYNC_ACCESS_EN <= 1'b1;
      PADS_HIZ <= 1'b0;
      SDRAM_SELF_REFRESH <= 1'b0;
      SEQ_RESET <= 1'b0;
      REG_WAKE <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      CORE_CLK_EN <= m_full || m_act;
      SYS_CLK_EN <= m_full || m_act || m_sleep;
      PLL_EN <= m_full || m_sleep || (m_act && !pll_off);
      PLL_BYPASS <= m_act;
      PLL_MULT <= applied_ff;
      DMA_L1_EN <= m_full || m_act;
      ASYNC_ACCESS_EN <= m_full || m_act || m_sleep;
      PADS_HIZ <= m_hib;
      SDRAM_SELF_REFRESH <= sdram_clock_enable_low && (m_hib || m_seq);
      SEQ_RESET <= m_seq;
      REG_WAKE <= !m_hib;
      IRQ <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign DAT_O = dat_ff;
  assign ACK_O = ack_ff;

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_FULL_CLOCKS: assert property (m_full |=>
    CORE_CLK_EN && SYS_CLK_EN && PLL_EN && !PLL_BYPASS)
    else $error("full-on clocks wrong");
  AST_ACT_BYPASS: assert property (m_act |=> PLL_BYPASS && CORE_CLK_EN && SYS_CLK_EN)
    else $error("active mode not bypassed");
  AST_MULT_HELD: assert property (m_act && $past(m_act) |-> $stable(applied_ff))
    else $error("multiplier changed in active mode");
  AST_SLEEP_CLOCKS: assert property (m_sleep |=> !CORE_CLK_EN && SYS_CLK_EN && PLL_EN)
    else $error("sleep clocks wrong");
  AST_SLEEP_WAKE: assert property (m_sleep && sleep_wake |=>
    state_ff == ($past(bypass_sel) ? pms_pkg::S_ACT : pms_pkg::S_FULL))
    else $error("sleep wakeup target wrong");
  AST_SLEEP_DMA: assert property (m_sleep |=> !DMA_L1_EN)
    else $error("DMA granted in sleep");
  AST_DEEP_HOLD: assert property (state_ff == pms_pkg::S_DEEP && !rtc_wake && !reset_pin |=>
    state_ff == pms_pkg::S_DEEP ##1 !SYS_CLK_EN && !PLL_EN)
    else $error("deep sleep left without cause");
  AST_DEEP_RTC: assert property (state_ff == pms_pkg::S_DEEP && rtc_wake && !reset_pin |=>
    m_act)
    else $error("rtc exit from deep sleep wrong");
  AST_DEEP_RESET: assert property (state_ff == pms_pkg::S_DEEP && reset_pin |=> m_full)
    else $error("reset exit from deep sleep wrong");
  AST_HIB_PADS: assert property (m_hib |=> PADS_HIZ && !REG_WAKE && !CORE_CLK_EN)
    else $error("hibernate outputs wrong");
  AST_HIB_KEEP: assert property (m_hib && !hib_wake |=> m_hib)
    else $error("hibernate left without enabled wake");
  AST_WIPE_PLL: assert property (m_seq |=> pll_control_reg_ff == pms_pkg::PLL_CONTROL_REG_RST)
    else $error("pll register kept across hibernate");
  AST_HIB_ENTRY: assert property (hib_wr |=> m_hib ##1 !REG_WAKE && PADS_HIZ)
    else $error("hibernate entry wrong");
  AST_HIB_WAKE: assert property (m_hib && hib_wake |=> m_seq ##1 REG_WAKE && SEQ_RESET)
    else $error("hibernate wake sequence wrong");
  AST_PG_WAIT: assert property (m_seq && !power_good |=> m_seq)
    else $error("started before power good");
  AST_SDRAM_SR: assert property (m_seq && sdram_clock_enable_low |=> SDRAM_SELF_REFRESH)
    else $error("self-refresh dropped in reset sequence");
endmodule

// >>> pms_partner.sv
// Far-side model: core regulator with power-good feedback, and a device that pulls the wake pin.
`timescale 1ns/1ps
module pms_partner #(
  parameter int PG_DELAY = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Regulator
  input wire logic reg_wake,
  output logic power_good_n,
  // Wake pin
  input wire logic pull_req,
  output logic wake_pin_n
);
  int cnt_ff;

  // The supply needs PG_DELAY cycles to ramp, so the sequencer must really wait for it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= PG_DELAY;
    end else if (!reg_wake) begin
      cnt_ff <= 0;
    end else if (cnt_ff < PG_DELAY) begin
      cnt_ff <= cnt_ff + 1;
    end
  end

  // Power good is pulled up, so it reads high while the supply is off or ramping.
  assign power_good_n = (cnt_ff < PG_DELAY);
  // The pin has a pull-up; any other device may pull it low.
  assign wake_pin_n = pull_req ? 1'b0 : 1'b1;
endmodule

// >>> tb_power_mode_sequencer.sv
// Self-checking testbench for the power mode sequencer.
`timescale 1ns/1ps
module tb_power_mode_sequencer;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] exp;
    logic [31:0] msk;
  } row_t;

  // Packed as core, sys, pll, bypass, dma, async, hiz, self-refresh, seq reset, reg wake.
  localparam logic [9:0] O_FULL = 10'h3B1;
  localparam logic [9:0] O_ACT = 10'h3F1;
  localparam logic [9:0] O_AOFF = 10'h371;
  localparam logic [9:0] O_SLP = 10'h181;
  localparam logic [9:0] M_SLP = 10'h3AB;
  localparam logic [9:0] O_DEEP = 10'h001;
  localparam logic [9:0] M_DEEP = 10'h39B;
  localparam logic [9:0] O_HIB = 10'h00C;
  localparam logic [9:0] M_HIB = 10'h38F;
  localparam logic [9:0] O_RST = 10'h007;
  localparam logic [9:0] M_RST = 10'h207;
  localparam logic [9:0] M_ALL = 10'h3FF;
  localparam logic [9:0] M_NOR = 10'h3FB;
  localparam logic [31:0] W = 32'hFFFF_FFFF;

  logic CLK = 1'b0;
  logic RST_N, CYC_I, STB_I, WE_I, ACK_O, IRQ, SLEEP_WAKE, RTC_WAKE, WAKE_PIN_N;
  logic RESET_PIN_N, POWER_GOOD_N, REG_WAKE, CORE_CLK_EN, SYS_CLK_EN, PLL_EN, PLL_BYPASS;
  logic DMA_L1_EN, ASYNC_ACCESS_EN, PADS_HIZ, SDRAM_SELF_REFRESH, SEQ_RESET, pull;
  logic [3:0] SEL_I;
  logic [7:0] ADR_I;
  logic [31:0] DAT_I, DAT_O, rd;
  logic [6:0] PLL_MULT;
  logic [9:0] outs;
  int n_mismatch = 0;
  int checked = 0;
  row_t rows [9] = '{
    '{1'b0, pms_pkg::PLL_CONTROL_REG_ADDR, 32'h0, 32'h0000_0006, W},
    '{1'b0, pms_pkg::REGULATOR_CONTROL_REG_ADDR, 32'h0, 32'h0000_0403, W},
    '{1'b0, pms_pkg::IRQ_MASK_ADDR, 32'h0, 32'h0, W},
    '{1'b0, pms_pkg::CMD_ADDR, 32'h0, 32'h0000_0600, 32'h0000_7F07},
    '{1'b0, 8'h14, 32'h0, 32'h0, W},
    '{1'b1, 8'h14, W, 32'h0, 32'h0},
    '{1'b0, 8'h14, 32'h0, 32'h0, W},
    '{1'b1, pms_pkg::IRQ_MASK_ADDR, 32'h0000_000F, 32'h0, 32'h0},
    '{1'b0, pms_pkg::IRQ_MASK_ADDR, 32'h0, 32'h0000_000F, W}
  };

  assign outs = {CORE_CLK_EN, SYS_CLK_EN, PLL_EN, PLL_BYPASS, DMA_L1_EN, ASYNC_ACCESS_EN,
                 PADS_HIZ, SDRAM_SELF_REFRESH, SEQ_RESET, REG_WAKE};

  always #12.5 CLK = ~CLK;

  power_mode_sequencer #(.MULT_W(7)) i_power_mode_sequencer (
    .CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .SEL_I(SEL_I),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ),
    .SLEEP_WAKE(SLEEP_WAKE), .RTC_WAKE(RTC_WAKE), .WAKE_PIN_N(WAKE_PIN_N),
    .RESET_PIN_N(RESET_PIN_N), .POWER_GOOD_N(POWER_GOOD_N), .REG_WAKE(REG_WAKE),
    .CORE_CLK_EN(CORE_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PLL_EN(PLL_EN),
    .PLL_BYPASS(PLL_BYPASS), .PLL_MULT(PLL_MULT), .DMA_L1_EN(DMA_L1_EN),
    .ASYNC_ACCESS_EN(ASYNC_ACCESS_EN), .PADS_HIZ(PADS_HIZ),
    .SDRAM_SELF_REFRESH(SDRAM_SELF_REFRESH), .SEQ_RESET(SEQ_RESET));

  pms_partner #(.PG_DELAY(20)) i_pms_partner (
    .clk(CLK), .rst_n(RST_N), .reg_wake(REG_WAKE), .power_good_n(POWER_GOOD_N),
    .pull_req(pull), .wake_pin_n(WAKE_PIN_N));

  // ******************************
  // Bus and compare tasks
  // ******************************
  // Entered just after a rising edge; holds the request until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= dat;
    SEL_I <= 4'hF;
    do begin
      @(posedge CLK);
    end while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic cmd(input logic [1:0] c);
    wb(1'b1, pms_pkg::CMD_ADDR, {30'h0, c});
  endtask

  task automatic wpll(input logic [31:0] d);
    wb(1'b1, pms_pkg::PLL_CONTROL_REG_ADDR, d);
  endtask

  task automatic settle();
    repeat (8) @(posedge CLK);
  endtask

  task automatic chk_outs(input string nm, input logic [9:0] exp, input logic [9:0] msk);
    checked++;
    if (((outs ^ exp) & msk) !== 10'h000) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp & msk, outs & msk);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got,
                          input logic [31:0] msk);
    checked++;
    if (((got ^ exp) & msk) !== 32'h0) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp & msk, got & msk);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ******************************
  // Stimulus
  // ******************************
  initial begin
    {RST_N, CYC_I, STB_I, WE_I, SLEEP_WAKE, RTC_WAKE, pull} = 7'h00;
    RESET_PIN_N = 1'b1;
    SEL_I = 4'h0;
    ADR_I = 8'h00;
    DAT_I = 32'h0;
    repeat (3) @(posedge CLK);
    chk_outs("reset outputs", O_FULL, M_ALL);
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk_word("register row", rows[i].exp, rd, rows[i].msk);
    end
    chk_word("power-up multiplier", 32'h6, {25'h0, PLL_MULT}, W);
    wpll(32'h0000_0106);
    cmd(pms_pkg::CMD_RUN);
    settle();
    chk_outs("active", O_ACT, M_ALL);
    wpll(32'h0000_010A);
    settle();
    chk_word("held multiplier", 32'h6, {25'h0, PLL_MULT}, W);
    wpll(32'h0000_000A);
    cmd(pms_pkg::CMD_RUN);
    settle();
    chk_outs("full-on", O_FULL, M_ALL);
    chk_word("applied multiplier", 32'hA, {25'h0, PLL_MULT}, W);
    wpll(32'h0000_030A);
    cmd(pms_pkg::CMD_RUN);
    settle();
    chk_outs("active pll off", O_AOFF, M_ALL);
    cmd(pms_pkg::CMD_SLEEP);
    settle();
    chk_outs("refused sleep", O_AOFF, M_ALL);
    chk_word("irq raised", 32'h1, {31'h0, IRQ}, W);
    wb(1'b0, pms_pkg::IRQ_STAT_ADDR, 32'h0);
    chk_word("refused status", 32'h8, rd, 32'hF);
    repeat (2) @(posedge CLK);
    chk_word("irq cleared", 32'h0, {31'h0, IRQ}, W);
    wpll(32'h0000_010A);
    cmd(pms_pkg::CMD_SLEEP);
    settle();
    chk_outs("sleep", O_SLP, M_SLP);
    SLEEP_WAKE <= 1'b1;
    settle();
    SLEEP_WAKE <= 1'b0;
    chk_outs("sleep to active", O_ACT, M_ALL);
    wb(1'b0, pms_pkg::IRQ_STAT_ADDR, 32'h0);
    chk_word("sleep exit status", 32'h1, rd, 32'h1);
    wpll(32'h0000_000A);
    cmd(pms_pkg::CMD_SLEEP);
    settle();
    SLEEP_WAKE <= 1'b1;
    settle();
    SLEEP_WAKE <= 1'b0;
    chk_outs("sleep to full-on", O_FULL, M_ALL);
    cmd(pms_pkg::CMD_DEEP);
    settle();
    chk_outs("deep sleep", O_DEEP, M_DEEP);
    SLEEP_WAKE <= 1'b1;
    pull <= 1'b1;
    settle();
    chk_outs("deep ignores wakes", O_DEEP, M_DEEP);
    SLEEP_WAKE <= 1'b0;
    pull <= 1'b0;
    RTC_WAKE <= 1'b1;
    settle();
    RTC_WAKE <= 1'b0;
    chk_outs("deep to active", O_ACT, M_ALL);
    wb(1'b0, pms_pkg::IRQ_STAT_ADDR, 32'h0);
    chk_word("deep exit status", 32'h2, rd, 32'h2);
    settle();
    cmd(pms_pkg::CMD_DEEP);
    settle();
    RESET_PIN_N <= 1'b0;
    settle();
    RESET_PIN_N <= 1'b1;
    chk_outs("deep to full-on", O_FULL, M_ALL);
    settle();
    wb(1'b1, pms_pkg::REGULATOR_CONTROL_REG_ADDR, 32'h0000_2500);
    settle();
    chk_outs("hibernate", O_HIB, M_HIB);
    RTC_WAKE <= 1'b1;
    settle();
    RTC_WAKE <= 1'b0;
    chk_outs("disabled wake", O_HIB, M_HIB);
    pull <= 1'b1;
    settle();
    pull <= 1'b0;
    chk_outs("reset sequence", O_RST, M_RST);
    repeat (10) @(posedge CLK);
    chk_outs("waiting for supply", O_RST, M_RST);
    repeat (20) @(posedge CLK);
    chk_outs("restart", O_FULL, M_NOR);
    chk_word("irq masked", 32'h0, {31'h0, IRQ}, W);
    wb(1'b0, pms_pkg::REGULATOR_CONTROL_REG_ADDR, 32'h0);
    chk_word("kept regulator reg", 32'h0000_2500, rd, W);
    wb(1'b0, pms_pkg::PLL_CONTROL_REG_ADDR, 32'h0);
    chk_word("lost pll reg", 32'h0000_0006, rd, W);
    wb(1'b0, pms_pkg::IRQ_STAT_ADDR, 32'h0);
    chk_word("hibernate wake status", 32'h4, rd, 32'h4);
    wpll(32'h0000_0106);
    cmd(pms_pkg::CMD_RUN);
    settle();
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    chk_outs("mid-run reset", O_FULL, M_ALL);
    RST_N <= 1'b1;
    @(posedge CLK);
    wb(1'b0, pms_pkg::PLL_CONTROL_REG_ADDR, 32'h0);
    chk_word("pll reg after reset", 32'h0000_0006, rd, W);
    results();
  end

  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    results();
  end
endmodule
